// >>> design/pdc_pkg.sv
// Package for the device capability and device control register block.
package pdc_pkg;

    // ------------------------------------------------------------------
    // Register offsets (configuration byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] PDC_DEV_CAP_OFS  = 8'h74;
    localparam logic [7:0] PDC_DEV_CTRL_OFS = 8'h78;
    localparam logic [7:0] PDC_GEN_CTRL_OFS = 8'hD4;

    // ------------------------------------------------------------------
    // Device capability field positions and constants
    // ------------------------------------------------------------------
    localparam int         PDC_CAP_ABP_BIT   = 12;
    localparam int         PDC_CAP_L1_LSB    = 9;
    localparam int         PDC_CAP_L0S_LSB   = 6;
    localparam int         PDC_CAP_EXTENDED_TAG_SUPPORTED_BIT  = 5;
    localparam int         PDC_CAP_PFS_LSB   = 3;
    localparam int         PDC_CAP_MAX_PAYLOAD_SUPPORTED_LSB  = 0;
    localparam logic [1:0] PDC_PFS_VAL       = 2'h0;
    localparam logic [2:0] PDC_MAX_PAYLOAD_SUPPORTED_VAL      = 3'h2;
    localparam logic [2:0] PDC_L1_RST        = 3'h6;
    localparam logic [2:0] PDC_L0S_RST       = 3'h6;

    // ------------------------------------------------------------------
    // General control latency field positions
    // ------------------------------------------------------------------
    localparam int         PDC_GEN_L1_LSB    = 13;
    localparam int         PDC_GEN_L0S_LSB   = 16;

    // ------------------------------------------------------------------
    // Device control field positions and reset values
    // ------------------------------------------------------------------
    localparam int          PDC_CTL_RETRY_BIT = 15;
    localparam int          PDC_CTL_MAX_READ_REQUEST_SIZE_LSB  = 12;
    localparam int          PDC_CTL_NS_BIT    = 11;
    localparam int          PDC_CTL_AUX_BIT   = 10;
    localparam int          PDC_CTL_PFE_BIT   = 9;
    localparam int          PDC_CTL_ETE_BIT   = 8;
    localparam int          PDC_CTL_MPS_LSB   = 5;
    localparam int          PDC_CTL_RO_BIT    = 4;
    localparam int          PDC_CTL_UR_BIT    = 3;
    localparam int          PDC_CTL_FE_BIT    = 2;
    localparam int          PDC_CTL_NFE_BIT   = 1;
    localparam int          PDC_CTL_CE_BIT    = 0;
    localparam logic [2:0]  PDC_MAX_READ_REQUEST_SIZE_RST      = 3'h2;
    localparam logic [2:0]  PDC_MPS_RST       = 3'h0;
    localparam logic [2:0]  PDC_SIZE_MAX_CODE = 3'h5;
    localparam logic [15:0] PDC_CTRL_RST      = 16'h2000;

    // ------------------------------------------------------------------
    // Grouped signals
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pdc_cfg_req_t;

    typedef struct packed {
        logic unsupported_req;
        logic fatal;
        logic nonfatal;
        logic correctable;
    } pdc_err_ev_t;

    typedef struct packed {
        logic err_nonfatal;
        logic err_fatal;
        logic err_cor;
    } pdc_err_msg_t;

endpackage

// >>> design/pdc_regs.sv
// Device capability and device control registers with error message gating.
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: Capability bit 12 reads zero; there is no attention button.
// RULE_02: Capability bits 11:9 mirror general control bits 15:13, reset 110b.
// RULE_03: L1 acceptable latency never holds less than the physical layer L1 exit latency.
// RULE_04: Capability bits 8:6 mirror general control bits 18:16, reset 110b.
// RULE_05: L0s acceptable latency never holds less than the physical layer L0s exit latency.
// RULE_06: Capability bit 5 reads zero; extended tags are not supported.
// RULE_07: Capability bits 4:3 read 00b; no phantom functions.
// RULE_08: Capability bits 2:0 read 010b, a 512 byte payload limit.
// RULE_09: With bit 15 set, a timed out forwarded config request returns retry status.
// RULE_10: With bit 15 clear, retry status completions are never produced.
// RULE_11: Bits 14:12 hold read request size, 128B doubling to 4096B, reset 010.
// RULE_12: Read fetches are limited to the programmed read request size.
// RULE_13: Control bit 11 reads zero; no-snoop is never set on initiated traffic.
// RULE_14: Control bit 10 is writable, resets zero and steers nothing.
// RULE_15: Control bit 9 reads zero; phantom functions unsupported.
// RULE_16: Control bit 8 reads zero; extended tags unsupported.
// RULE_17: Bits 7:5 cap posted write and completion payload, reset 000 (128B).
// RULE_18: Control bit 4 reads zero; relaxed ordering unsupported.
// RULE_19: Bit 3 set sends a nonfatal message on an unsupported request.
// RULE_20: Bit 2 set sends a fatal message on a fatal error event.
// RULE_21: Bit 1 set sends a nonfatal message on a nonfatal error event.
// RULE_22: Bit 0 set sends a correctable message on a correctable error event.
// RULE_23: Writes to read-only or hardwired bits are ignored.
module pdc_regs #(
    parameter int SIZE_W = 13
) (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    // Configuration access
    input  wire pdc_pkg::pdc_cfg_req_t cfg_req_i,
    output logic [31:0]                cfg_rdata_o,
    output logic                       cfg_rvalid_o,
    // Physical layer exit latencies
    input  wire logic [2:0]            phy_l1_exit_lat_i,
    input  wire logic [2:0]            phy_l0s_exit_lat_i,
    // Forwarded configuration request tracking
    input  wire logic                  cfg_fwd_timeout_i,
    output logic                       cfg_retry_cpl_o,
    // Error events and messages
    input  wire pdc_pkg::pdc_err_ev_t  err_ev_i,
    output pdc_pkg::pdc_err_msg_t      err_msg_o,
    // Transaction sizing and attributes
    output logic [SIZE_W-1:0]          max_read_bytes_o,
    output logic [SIZE_W-1:0]          max_payload_bytes_o,
    output logic                       no_snoop_o
);
    import pdc_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Reserved size codes clamp to the largest legal size so a fetch never
    // exceeds 4096 bytes.
    function automatic logic [SIZE_W-1:0] size_bytes(input logic [2:0] code);
        logic [2:0] c;
        c = (code > PDC_SIZE_MAX_CODE) ? PDC_SIZE_MAX_CODE : code;
        return SIZE_W'(13'd128 << c);
    endfunction

    function automatic logic [2:0] lat_floor(input logic [2:0] req, input logic [2:0] phy);
        return (req < phy) ? phy : req;
    endfunction

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic hit_ctrl = cfg_req_i.wr && (cfg_req_i.addr == PDC_DEV_CTRL_OFS);
    wire logic hit_gen  = cfg_req_i.wr && (cfg_req_i.addr == PDC_GEN_CTRL_OFS);
    wire logic [15:0] wd = cfg_req_i.wdata[15:0];
    wire logic [18:0] gd = cfg_req_i.wdata[18:0];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic       retry_en_ff;
    logic [2:0] max_read_request_size_ff;
    logic       aux_pm_ff;
    logic [2:0] mps_ff;
    logic       ur_en_ff;
    logic       fe_en_ff;
    logic       nfe_en_ff;
    logic       ce_en_ff;
    logic [2:0] l1_lat_ff;
    logic [2:0] l0s_lat_ff;

    // Byte lane 1 carries bits 15:8, lane 0 bits 7:0; hardwired bits have
    // no storage so writes to them vanish.
    wire logic nxt_retry_en = (hit_ctrl && cfg_req_i.be[1]) ? wd[PDC_CTL_RETRY_BIT] : retry_en_ff; // RULE_09
    wire logic [2:0] nxt_max_read_request_size = (hit_ctrl && cfg_req_i.be[1]) ? wd[PDC_CTL_MAX_READ_REQUEST_SIZE_LSB+:3] : max_read_request_size_ff; // RULE_11
    wire logic nxt_aux_pm = (hit_ctrl && cfg_req_i.be[1]) ? wd[PDC_CTL_AUX_BIT] : aux_pm_ff; // RULE_14
    wire logic [2:0] nxt_mps = (hit_ctrl && cfg_req_i.be[0]) ? wd[PDC_CTL_MPS_LSB+:3] : mps_ff; // RULE_17
    wire logic nxt_ur_en  = (hit_ctrl && cfg_req_i.be[0]) ? wd[PDC_CTL_UR_BIT] : ur_en_ff;   // RULE_19
    wire logic nxt_fe_en  = (hit_ctrl && cfg_req_i.be[0]) ? wd[PDC_CTL_FE_BIT] : fe_en_ff;   // RULE_20
    wire logic nxt_nfe_en = (hit_ctrl && cfg_req_i.be[0]) ? wd[PDC_CTL_NFE_BIT] : nfe_en_ff; // RULE_21
    wire logic nxt_ce_en  = (hit_ctrl && cfg_req_i.be[0]) ? wd[PDC_CTL_CE_BIT] : ce_en_ff;   // RULE_22
    wire logic [2:0] l1_wr   = cfg_req_i.be[1] ? gd[PDC_GEN_L1_LSB+:3] : l1_lat_ff;
    wire logic [2:0] l0s_wr  = cfg_req_i.be[2] ? gd[PDC_GEN_L0S_LSB+:3] : l0s_lat_ff;
    // The floor is applied every cycle so a later rise in PHY latency is
    // also honoured, not only at write time.
    wire logic [2:0] nxt_l1  = lat_floor(hit_gen ? l1_wr : l1_lat_ff, phy_l1_exit_lat_i); // RULE_02 RULE_03
    wire logic [2:0] nxt_l0s = lat_floor(hit_gen ? l0s_wr : l0s_lat_ff, phy_l0s_exit_lat_i); // RULE_04 RULE_05

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            retry_en_ff <= PDC_CTRL_RST[PDC_CTL_RETRY_BIT];
        end else begin
            retry_en_ff <= nxt_retry_en;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            max_read_request_size_ff <= PDC_MAX_READ_REQUEST_SIZE_RST;
        end else begin
            max_read_request_size_ff <= nxt_max_read_request_size;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            aux_pm_ff <= PDC_CTRL_RST[PDC_CTL_AUX_BIT];
        end else begin
            aux_pm_ff <= nxt_aux_pm;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            mps_ff <= PDC_MPS_RST;
        end else begin
            mps_ff <= nxt_mps;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ur_en_ff <= PDC_CTRL_RST[PDC_CTL_UR_BIT];
        end else begin
            ur_en_ff <= nxt_ur_en;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            fe_en_ff <= PDC_CTRL_RST[PDC_CTL_FE_BIT];
        end else begin
            fe_en_ff <= nxt_fe_en;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            nfe_en_ff <= PDC_CTRL_RST[PDC_CTL_NFE_BIT];
        end else begin
            nfe_en_ff <= nxt_nfe_en;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ce_en_ff <= PDC_CTRL_RST[PDC_CTL_CE_BIT];
        end else begin
            ce_en_ff <= nxt_ce_en;
        end
    end

    // ------------------------------------------------------------------
    // Latency fields
    // ------------------------------------------------------------------
    // The reset value can sit below a slow PHY for one cycle; the floor
    // lifts it on the first edge after reset.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            l1_lat_ff <= PDC_L1_RST;
        end else begin
            l1_lat_ff <= nxt_l1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            l0s_lat_ff <= PDC_L0S_RST;
        end else begin
            l0s_lat_ff <= nxt_l0s;
        end
    end

    // ------------------------------------------------------------------
    // Read assembly
    // ------------------------------------------------------------------
    wire logic [31:0] cap_word = {16'h0000, 1'b0, 1'b0, 1'b0,
                                  1'b0,                        // RULE_01
                                  l1_lat_ff, l0s_lat_ff,       // RULE_02 RULE_04
                                  1'b0,                        // RULE_06
                                  PDC_PFS_VAL,                 // RULE_07
                                  PDC_MAX_PAYLOAD_SUPPORTED_VAL};               // RULE_08
    wire logic [15:0] ctrl_word = {retry_en_ff, max_read_request_size_ff,     // RULE_23
                                   1'b0,                       // RULE_13
                                   aux_pm_ff,
                                   1'b0, 1'b0,                 // RULE_15 RULE_16
                                   mps_ff,
                                   1'b0,                       // RULE_18
                                   ur_en_ff, fe_en_ff, nfe_en_ff, ce_en_ff};
    wire logic [31:0] gen_word = {13'h0000,
                                  l0s_lat_ff,                  // RULE_04
                                  l1_lat_ff,                   // RULE_02
                                  13'h0000};
    wire logic [31:0] nxt_rdata = (cfg_req_i.addr == PDC_DEV_CAP_OFS)  ? cap_word
                                : (cfg_req_i.addr == PDC_DEV_CTRL_OFS) ? {16'h0000, ctrl_word}
                                : (cfg_req_i.addr == PDC_GEN_CTRL_OFS) ? gen_word
                                : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    pdc_err_msg_t nxt_msg;
    assign nxt_msg.err_nonfatal = (err_ev_i.unsupported_req && ur_en_ff)    // RULE_19
                                || (err_ev_i.nonfatal && nfe_en_ff);         // RULE_21
    assign nxt_msg.err_fatal    = err_ev_i.fatal && fe_en_ff;                // RULE_20
    assign nxt_msg.err_cor      = err_ev_i.correctable && ce_en_ff;          // RULE_22

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cfg_rdata_o <= 32'h0000_0000;
        end else begin
            cfg_rdata_o <= cfg_req_i.rd ? nxt_rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cfg_rvalid_o <= 1'b0;
        end else begin
            cfg_rvalid_o <= cfg_req_i.rd;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cfg_retry_cpl_o <= 1'b0;
        end else begin
            cfg_retry_cpl_o <= cfg_fwd_timeout_i && retry_en_ff; // RULE_09 RULE_10
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            err_msg_o <= '0;
        end else begin
            err_msg_o <= nxt_msg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            max_read_bytes_o <= SIZE_W'(13'd512);
        end else begin
            max_read_bytes_o <= size_bytes(max_read_request_size_ff); // RULE_12
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            max_payload_bytes_o <= SIZE_W'(13'd128);
        end else begin
            max_payload_bytes_o <= size_bytes(mps_ff); // RULE_17
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            no_snoop_o <= 1'b0;
        end else begin
            no_snoop_o <= 1'b0; // RULE_13
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    l1_floor_a: assert property (l1_lat_ff >= $past(phy_l1_exit_lat_i)) // RULE_03
        else $error("L1_accept_latency_prog below phy exit latency");
    l0s_floor_a: assert property (l0s_lat_ff >= $past(phy_l0s_exit_lat_i)) // RULE_05
        else $error("L0s_accept_latency_prog below phy exit latency");
    cap_const_a: assert property (cfg_req_i.rd && cfg_req_i.addr == PDC_DEV_CAP_OFS |=> // RULE_08
        cfg_rdata_o[5:0] == 6'h02 && cfg_rdata_o[12] == 1'b0) else $error("capability constants wrong");
    ctrl_ro_a: assert property (cfg_req_i.rd && cfg_req_i.addr == PDC_DEV_CTRL_OFS |=> // RULE_23
        cfg_rdata_o[11:8] == {1'b0, cfg_rdata_o[10], 2'b00} && cfg_rdata_o[4] == 1'b0)
        else $error("hardwired control bits not zero");
    retry_gate_a: assert property (!retry_en_ff |=> !cfg_retry_cpl_o) // RULE_10
        else $error("retry completion while disabled");
    retry_fire_a: assert property (retry_en_ff && cfg_fwd_timeout_i |=> cfg_retry_cpl_o) // RULE_09
        else $error("missing retry completion");
    fatal_msg_a: assert property (err_ev_i.fatal && fe_en_ff |=> err_msg_o.err_fatal) // RULE_20
        else $error("fatal message missing");
    cor_gate_a: assert property (!ce_en_ff |=> !err_msg_o.err_cor) // RULE_22
        else $error("correctable message while disabled");
    ur_msg_a: assert property (err_ev_i.unsupported_req && ur_en_ff |=> err_msg_o.err_nonfatal) // RULE_19
        else $error("unsupported request message missing");
    nf_msg_a: assert property (err_ev_i.nonfatal && nfe_en_ff |=> err_msg_o.err_nonfatal) // RULE_21
        else $error("nonfatal message missing");
    max_read_request_size_size_a: assert property (max_read_request_size_ff == 3'h0 |=> max_read_bytes_o == SIZE_W'(13'd128)) // RULE_12
        else $error("read size mapping wrong");
    mps_wr_a: assert property (hit_ctrl && cfg_req_i.be[0] |=> mps_ff == $past(wd[7:5])) // RULE_17
        else $error("payload size not written");
    max_read_request_size_wr_a: assert property (hit_ctrl && cfg_req_i.be[1] |=> max_read_request_size_ff == $past(wd[14:12])) // RULE_11
        else $error("read request size not written");
    aux_wr_a: assert property (hit_ctrl && cfg_req_i.be[1] |=> aux_pm_ff == $past(wd[10])) // RULE_14
        else $error("aux power enable not written");
    rd_clamp_a: assert property (max_read_request_size_ff > PDC_SIZE_MAX_CODE |=> max_read_bytes_o == SIZE_W'(13'd4096)) // RULE_12
        else $error("reserved read size not clamped");

    // ------------------------------------------------------------------
    // Latency mirror checks
    // ------------------------------------------------------------------
    l1_mirror_a: assert property (hit_gen && cfg_req_i.be[1] && gd[15:13] >= phy_l1_exit_lat_i // RULE_02
        |=> l1_lat_ff == $past(gd[15:13])) else $error("L1_accept_latency_prog not mirrored");
    l0s_mirror_a: assert property (hit_gen && cfg_req_i.be[2] && gd[18:16] >= phy_l0s_exit_lat_i // RULE_04
        |=> l0s_lat_ff == $past(gd[18:16])) else $error("L0s_accept_latency_prog not mirrored");

    retry_cv: cover property (retry_en_ff && cfg_fwd_timeout_i);
    fatal_cv: cover property (err_msg_o.err_fatal);
    floor_cv: cover property (hit_gen && l1_wr < phy_l1_exit_lat_i);
    ctrl_wr_cv: cover property (hit_ctrl ##1 cfg_req_i.rd && cfg_req_i.addr == PDC_DEV_CTRL_OFS);
    clamp_cv: cover property (max_read_request_size_ff > PDC_SIZE_MAX_CODE);

endmodule // pdc_regs

// >>> verif/pdc_host_model.sv
// Host side model that issues configuration reads and writes to the register block.
`timescale 1ns/1ps
module pdc_host_model (
    // Clock
    input  wire logic             ref_clk_i,
    // Configuration access
    output pdc_pkg::pdc_cfg_req_t cfg_req_o,
    input  wire logic [31:0]      cfg_rdata_i,
    input  wire logic             cfg_rvalid_i
);
    import pdc_pkg::*;
    initial cfg_req_o = '0;
    // Released lines carry the inverse so that a stale address or data value never looks valid.
    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge ref_clk_i);
        cfg_req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
        @(posedge ref_clk_i);
        cfg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, be: ~be, wdata: ~d};
    endtask
    task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d, output logic v);
        @(posedge ref_clk_i);
        cfg_req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hF, wdata: 32'h0000_0000};
        @(posedge ref_clk_i);
        cfg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, be: 4'h0, wdata: 32'hFFFF_FFFF};
        #1;
        v = cfg_rvalid_i;
        d = cfg_rdata_i;
    endtask
endmodule // pdc_host_model

// >>> verif/pcie_device_cap_ctrl_regs_bench.sv
// Self-checking bench for the device capability and device control registers.
`timescale 1ns/1ps
module pcie_device_cap_ctrl_regs_bench;
    import pdc_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, tmo = 1'b0, rvalid, no_snoop, retry;
    logic [2:0] phy_l1 = 3'h0, phy_l0s = 3'h0;
    logic [31:0] rdata;
    logic [12:0] max_rd, max_pl;
    pdc_cfg_req_t cfg_req;
    pdc_err_ev_t err_ev = '0;
    pdc_err_msg_t err_msg;
    int fail_count = 0, checked = 0;
    always #10 ref_clk = ~ref_clk;
    pdc_regs i_pdc_regs (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .cfg_req_i(cfg_req), .cfg_rdata_o(rdata),
        .cfg_rvalid_o(rvalid), .phy_l1_exit_lat_i(phy_l1), .phy_l0s_exit_lat_i(phy_l0s),
        .cfg_fwd_timeout_i(tmo), .cfg_retry_cpl_o(retry), .err_ev_i(err_ev), .err_msg_o(err_msg),
        .max_read_bytes_o(max_rd), .max_payload_bytes_o(max_pl), .no_snoop_o(no_snoop));
    pdc_host_model i_pdc_host_model (.ref_clk_i(ref_clk), .cfg_req_o(cfg_req), .cfg_rdata_i(rdata),
        .cfg_rvalid_i(rvalid));
    // ------------------------------------------------------------------
    // Comparison and closing
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        logic v;
        i_pdc_host_model.cfg_rd(a, d, v);
        chk({n, " valid"}, 32'h1, {31'h0, v});
        chk(n, e, d & m);
    endtask
    // One event cycle; messages and retry land on the same edge that samples the event.
    task automatic pulse(input pdc_err_ev_t ev, input logic t, input logic [3:0] e);
        @(posedge ref_clk);
        err_ev <= ev;
        tmo    <= t;
        @(posedge ref_clk);
        err_ev <= '0;
        tmo    <= 1'b0;
        #1;
        chk("messages", {28'h0, e}, {28'h0, err_msg, retry});
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd_chk("ctrl reset", PDC_DEV_CTRL_OFS, 32'h0000_2000, 32'h0000_FFFF);
        rd_chk("cap reset", PDC_DEV_CAP_OFS, 32'h0000_0D82, 32'h0000_1FFF);
        chk("max read", 32'd512, {19'h0, max_rd});
        chk("max payload", 32'd128, {19'h0, max_pl});
        chk("no snoop", 32'h0, {31'h0, no_snoop});
    endtask
    task automatic t_hardwired();
        i_pdc_host_model.cfg_wr(PDC_DEV_CTRL_OFS, 4'h3, 32'h0000_FFFF);
        rd_chk("ctrl ones", PDC_DEV_CTRL_OFS, 32'h0000_F4EF, 32'h0000_FFFF);
        chk("no snoop", 32'h0, {31'h0, no_snoop});
        i_pdc_host_model.cfg_wr(PDC_DEV_CTRL_OFS, 4'h0, 32'h0000_0000);
        rd_chk("ctrl no lanes", PDC_DEV_CTRL_OFS, 32'h0000_F4EF, 32'h0000_FFFF);
        i_pdc_host_model.cfg_wr(PDC_DEV_CAP_OFS, 4'hF, 32'hFFFF_FFFF);
        rd_chk("cap after write", PDC_DEV_CAP_OFS, 32'h0000_0D82, 32'h0000_1FFF);
        rd_chk("unmapped", 8'h80, 32'h0000_0000, 32'hFFFF_FFFF);
    endtask
    task automatic t_sizes();
        for (int c = 0; c < 8; c++) begin
            i_pdc_host_model.cfg_wr(PDC_DEV_CTRL_OFS, 4'h3, (c << 12) | (c << 5));
            repeat (2) @(posedge ref_clk);
            #1;
            chk("max read", 32'd128 << ((c > 5) ? 5 : c), {19'h0, max_rd});
            chk("max payload", 32'd128 << ((c > 5) ? 5 : c), {19'h0, max_pl});
        end
        rd_chk("reserved codes", PDC_DEV_CTRL_OFS, 32'h0000_70E0, 32'h0000_FFFF);
    endtask
    task automatic t_errors();
        logic [2:0] m;
        for (int i = 0; i < 4; i++) begin
            m = (i == 2) ? 3'b010 : (i == 0) ? 3'b001 : 3'b100;
            i_pdc_host_model.cfg_wr(PDC_DEV_CTRL_OFS, 4'h3, 32'h1 << i);
            pulse(pdc_err_ev_t'(4'h1 << i), 1'b0, {m, 1'b0});
            i_pdc_host_model.cfg_wr(PDC_DEV_CTRL_OFS, 4'h3, 32'h0000_040F & ~(32'h1 << i));
            pulse(pdc_err_ev_t'(4'h1 << i), 1'b0, 4'h0);
        end
        i_pdc_host_model.cfg_wr(PDC_DEV_CTRL_OFS, 4'h3, 32'h0000_8000);
        pulse('0, 1'b1, 4'h1);
        i_pdc_host_model.cfg_wr(PDC_DEV_CTRL_OFS, 4'h3, 32'h0000_74EF);
        pulse('0, 1'b1, 4'h0);
    endtask
    task automatic t_latency();
        @(posedge ref_clk);
        phy_l1  <= 3'h1;
        phy_l0s <= 3'h1;
        i_pdc_host_model.cfg_wr(PDC_GEN_CTRL_OFS, 4'h6, 32'h0002_6000);
        rd_chk("cap latency", PDC_DEV_CAP_OFS, 32'h0000_0680, 32'h0000_0FC0);
        rd_chk("gen latency", PDC_GEN_CTRL_OFS, 32'h0002_6000, 32'hFFFF_FFFF);
        @(posedge ref_clk);
        phy_l1  <= 3'h4;
        phy_l0s <= 3'h5;
        i_pdc_host_model.cfg_wr(PDC_GEN_CTRL_OFS, 4'h6, 32'h0000_0000);
        rd_chk("cap floor", PDC_DEV_CAP_OFS, 32'h0000_0940, 32'h0000_0FC0);
        rd_chk("gen floor", PDC_GEN_CTRL_OFS, 32'h0005_8000, 32'hFFFF_FFFF);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_hardwired();
        t_sizes();
        t_errors();
        t_latency();
        report_and_stop();
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        report_and_stop();
    end
endmodule // pcie_device_cap_ctrl_regs_bench
